// ==== eir_event_interrupt_router.sv ====
// event interrupt router: source routing, nonmaskables, wakeup, avalon registers
`default_nettype none

module eir_event_interrupt_router #(
   parameter int PERIPH_COUNT = eir_pkg::PERIPH_COUNT,
   parameter int PIN_COUNT = eir_pkg::PIN_COUNT,
   localparam int SRC = PERIPH_COUNT + PIN_COUNT,
   localparam int SW = eir_pkg::STAT_PIN_LSB + PIN_COUNT + 1
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // avalon-mm slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // event sources
   input wire logic [PERIPH_COUNT-1:0] periph_event,
   input wire logic [PIN_COUNT-1:0] ext_request_pin,
   input wire logic nmi_pin,
   input wire logic independent_watchdog_underflow,
   input wire logic independent_watchdog_refresh_error,
   input wire logic voltage_monitor_one_event,
   input wire logic vmon1_irq_select,
   input wire logic ram_parity_event,
   input wire logic [1:0] power_mode,
   // requests out
   output logic [SRC-1:0] cpu_vector_request,
   output logic [SRC-1:0] transfer_request,
   output logic nonmaskable_request,
   output logic wake_request,
   output logic irq
);

   // ==========================================================
   // helpers
   localparam logic [63:0] SRC_MASK = {64{1'b1}} >> (64 - SRC);
   localparam int WAKE_BIT = SW - 1;

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // ==========================================================
   // register state
   logic [63:0] irq_en;
   logic [63:0] xfer_en;
   logic [63:0] standby_end_select;
   logic [31:0] ext_request_edge_cfg;
   logic nmi_edge;
   logic [eir_pkg::NM_COUNT-1:0] nonmaskable_enable_reg;
   logic [SW-1:0] status;
   logic [SW-1:0] int_mask;

   // next values, built by the processes below
   logic [63:0] next_irq_en;
   logic [63:0] next_xfer_en;
   logic [63:0] next_standby_end_select;
   logic [31:0] next_ext_request_edge_cfg;
   logic next_nmi_edge;
   logic [eir_pkg::NM_COUNT-1:0] next_nonmaskable_enable_reg;
   logic [SW-1:0] next_status;
   logic [SW-1:0] next_int_mask;
   logic [31:0] next_readdata;
   logic next_waitrequest;

   // next values of the registered outputs
   logic [SRC-1:0] next_cpu_vector_request;
   logic [SRC-1:0] next_transfer_request;
   logic next_nonmaskable_request;
   logic next_wake_request;
   logic next_irq;

   // ==========================================================
   // pin edge detection, one detector per pin plus the nmi pin
   logic [PIN_COUNT-1:0] pin_detect;
   logic nmi_detect;

   for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
      eir_pin_edge u_edge (
         .clock(clock),
         .rst(rst),
         .ce(ce),
         .pin(ext_request_pin[g]),
         .edge_sel(ext_request_edge_cfg[2*g +: 2]), // R15
         .detect(pin_detect[g]) // R4
      );
   end

   // nmi only offers rising or falling, never both
   eir_pin_edge u_nmi_edge (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .pin(nmi_pin),
      .edge_sel(nmi_edge ? eir_pkg::EDGE_RISE : eir_pkg::EDGE_FALL), // R7
      .detect(nmi_detect)
   );

   // ==========================================================
   // combined source vector: peripherals low, pins above
   logic [SRC-1:0] src_event;
   logic [eir_pkg::NM_COUNT-1:0] nm_set;
   logic accept_wr;
   logic accept_rd;
   logic [SW-1:0] read_clear;
   logic nm_pending;
   logic wake_cond;

   always_comb begin
      src_event = {pin_detect, periph_event}; // R2
      nm_set = '0;
      nm_set[eir_pkg::NM_PIN] = nmi_detect; // R7
      nm_set[eir_pkg::NM_WATCHDOG] = independent_watchdog_underflow
                                     | independent_watchdog_refresh_error; // R8
      // monitor events count only once software selected them
      nm_set[eir_pkg::NM_VMON] = voltage_monitor_one_event & vmon1_irq_select; // R9 R14
      nm_set[eir_pkg::NM_PARITY] = ram_parity_event; // R10
   end

   // ==========================================================
   // avalon slave: one wait cycle, then the request is taken
   always_comb begin
      accept_wr = write & ~waitrequest;
      accept_rd = read & ~waitrequest;

      // idle answer is busy, so a request always waits once
      next_waitrequest = eir_pkg::RST_WAITREQUEST;
      if ((read || write) && waitrequest) begin
         next_waitrequest = 1'b0;
      end
   end

   // read data captured in the wait cycle so it stands at the taking edge
   always_comb begin
      next_readdata = readdata;
      if (read && waitrequest) begin
         case (address)
            eir_pkg::OFS_IRQ_EN_LO: next_readdata = irq_en[31:0];
            eir_pkg::OFS_IRQ_EN_HI: next_readdata = irq_en[63:32];
            eir_pkg::OFS_XFER_EN_LO: next_readdata = xfer_en[31:0];
            eir_pkg::OFS_XFER_EN_HI: next_readdata = xfer_en[63:32];
            eir_pkg::OFS_STANDBY_END_SELECT0: next_readdata = standby_end_select[31:0];
            eir_pkg::OFS_STANDBY_END_SELECT1: next_readdata = standby_end_select[63:32];
            eir_pkg::OFS_EXT_EDGE_CFG: next_readdata = ext_request_edge_cfg;
            eir_pkg::OFS_NMI_EDGE: next_readdata = {31'h0, nmi_edge};
            eir_pkg::OFS_NONMASKABLE_ENABLE: next_readdata = 32'(nonmaskable_enable_reg);
            eir_pkg::OFS_INT_STATUS: next_readdata = 32'(status);
            eir_pkg::OFS_INT_MASK: next_readdata = 32'(int_mask);
            default: next_readdata = 32'h0; // unmapped reads zero
         endcase
      end
   end

   // register writes at the taking edge
   always_comb begin
      next_irq_en = irq_en;
      next_xfer_en = xfer_en;
      next_standby_end_select = standby_end_select;
      next_ext_request_edge_cfg = ext_request_edge_cfg;
      next_nmi_edge = nmi_edge;
      next_nonmaskable_enable_reg = nonmaskable_enable_reg;
      next_int_mask = int_mask;
      if (accept_wr) begin
         case (address)
            eir_pkg::OFS_IRQ_EN_LO:
               next_irq_en[31:0] = merge(irq_en[31:0], writedata, byteenable);
            eir_pkg::OFS_IRQ_EN_HI:
               next_irq_en[63:32] = merge(irq_en[63:32], writedata, byteenable);
            eir_pkg::OFS_XFER_EN_LO:
               next_xfer_en[31:0] = merge(xfer_en[31:0], writedata, byteenable);
            eir_pkg::OFS_XFER_EN_HI:
               next_xfer_en[63:32] = merge(xfer_en[63:32], writedata, byteenable);
            eir_pkg::OFS_STANDBY_END_SELECT0: next_standby_end_select[31:0] =
               merge(standby_end_select[31:0], writedata, byteenable); // R12
            eir_pkg::OFS_STANDBY_END_SELECT1: next_standby_end_select[63:32] =
               merge(standby_end_select[63:32], writedata, byteenable); // R12
            eir_pkg::OFS_EXT_EDGE_CFG: next_ext_request_edge_cfg =
               merge(ext_request_edge_cfg, writedata, byteenable)
               & ({32{1'b1}} >> (32 - 2 * PIN_COUNT)); // R15
            eir_pkg::OFS_NMI_EDGE: begin
               if (byteenable[0]) begin
                  next_nmi_edge = writedata[0]; // R7
               end
            end
            eir_pkg::OFS_NONMASKABLE_ENABLE: begin
               // set-only: a stray write can never switch an nmi source off
               if (byteenable[0]) begin
                  next_nonmaskable_enable_reg = nonmaskable_enable_reg
                     | writedata[eir_pkg::NM_COUNT-1:0]; // R1
               end
            end
            eir_pkg::OFS_INT_MASK: next_int_mask =
               SW'(merge(32'(int_mask), writedata, byteenable));
            default: ; // unmapped writes ignored
         endcase
         // storage beyond the real source count stays zero
         next_irq_en = next_irq_en & SRC_MASK;
         next_xfer_en = next_xfer_en & SRC_MASK;
         next_standby_end_select = next_standby_end_select & SRC_MASK;
      end
   end

   // ==========================================================
   // sticky status: clearing by read uses the captured word, so
   // events arriving after the capture survive, and a set beats a clear
   always_comb begin
      nm_pending = |(status[eir_pkg::NM_COUNT-1:0] & nonmaskable_enable_reg);
      // run mode never asks for a wake
      case (power_mode)
         eir_pkg::MODE_SLEEP:
            wake_cond = nm_pending | (|(src_event & irq_en[SRC-1:0])); // R11
         eir_pkg::MODE_STANDBY:
            wake_cond = nm_pending | (|(src_event & standby_end_select[SRC-1:0])); // R12
         eir_pkg::MODE_SNOOZE:
            wake_cond = nm_pending | (|(src_event & standby_end_select[SRC-1:0])); // R13
         default: wake_cond = 1'b0;
      endcase

      // a read clears only the bits that it returned
      read_clear = '0;
      if (accept_rd && address == eir_pkg::OFS_INT_STATUS) begin
         read_clear = readdata[SW-1:0];
      end
      next_status = status & ~read_clear; // R16
      next_status[eir_pkg::NM_COUNT-1:0] = next_status[eir_pkg::NM_COUNT-1:0] | nm_set; // R16
      next_status[eir_pkg::STAT_PIN_LSB +: PIN_COUNT] =
         next_status[eir_pkg::STAT_PIN_LSB +: PIN_COUNT] | pin_detect;
      next_status[WAKE_BIT] = next_status[WAKE_BIT] | wake_cond;
   end

   // ==========================================================
   // registered request outputs, all gated by enables cleared at reset
   always_comb begin
      next_cpu_vector_request = src_event & irq_en[SRC-1:0]; // R5 R17
      next_transfer_request = src_event & xfer_en[SRC-1:0]; // R6 R17
      next_nonmaskable_request =
         |(next_status[eir_pkg::NM_COUNT-1:0] & nonmaskable_enable_reg); // R1 R17
      next_wake_request = wake_cond;
      // a new mask acts at once, as a status read does
      next_irq = |(next_status & next_int_mask);
   end

   // ==========================================================
   // state registers; ce low freezes everything
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_en <= eir_pkg::RST_ENABLE; // R17
         xfer_en <= eir_pkg::RST_ENABLE; // R17
         standby_end_select <= eir_pkg::RST_ENABLE;
         ext_request_edge_cfg <= eir_pkg::RST_WORD;
         nmi_edge <= eir_pkg::RST_FLAG;
         nonmaskable_enable_reg <= '0; // R17
         status <= '0;
         int_mask <= '0;

         readdata <= eir_pkg::RST_WORD;
         waitrequest <= eir_pkg::RST_WAITREQUEST;

         cpu_vector_request <= '0;
         transfer_request <= '0;
         nonmaskable_request <= eir_pkg::RST_FLAG;
         wake_request <= eir_pkg::RST_FLAG;
         irq <= eir_pkg::RST_FLAG;
      end else if (ce) begin
         irq_en <= next_irq_en;
         xfer_en <= next_xfer_en;
         standby_end_select <= next_standby_end_select;
         ext_request_edge_cfg <= next_ext_request_edge_cfg;
         nmi_edge <= next_nmi_edge;
         nonmaskable_enable_reg <= next_nonmaskable_enable_reg;
         status <= next_status;
         int_mask <= next_int_mask;

         readdata <= next_readdata;
         waitrequest <= next_waitrequest;

         cpu_vector_request <= next_cpu_vector_request;
         transfer_request <= next_transfer_request;
         nonmaskable_request <= next_nonmaskable_request;
         wake_request <= next_wake_request;
         irq <= next_irq;
      end
   end

endmodule : eir_event_interrupt_router

`default_nettype wire

// ==== eir_pin_edge.sv ====
// pin synchroniser and selectable edge detector
`default_nettype none

module eir_pin_edge (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic pin,
   input wire logic [1:0] edge_sel,
   output logic detect
);

   // ==========================================================
   // sync[0] feeds only sync[1]; sync[2] holds the previous level
   logic [2:0] sync;
   logic [2:0] next_sync;
   logic next_detect;
   logic rise;
   logic fall;

   // edge decode on synchronised levels only
   always_comb begin
      next_sync = {sync[1:0], pin}; // R16
      rise = sync[1] & ~sync[2];
      fall = ~sync[1] & sync[2];
      case (edge_sel)
         eir_pkg::EDGE_FALL: next_detect = fall; // R3
         eir_pkg::EDGE_RISE: next_detect = rise; // R3
         default: next_detect = rise | fall; // R3
      endcase
   end

   // registers frozen while ce is low
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync <= 3'h0;
         detect <= eir_pkg::RST_FLAG;
      end else if (ce) begin
         sync <= next_sync;
         detect <= next_detect;
      end
   end

endmodule : eir_pin_edge

`default_nettype wire

// ==== eir_pkg.sv ====
// constants shared by the event interrupt router files
// How it works
// R1: route events to CPU, transfer controller, nonmaskables
// R2: accept 33 peripheral maskable event sources
// R3: per pin edge: falling, rising or both
// R4: six external request pins, numbered 0 to 5
// R5: drive 39 maskable requests to CPU controller
// R6: transfer triggers selected like CPU requests
// R7: NMI pin edge: falling or rising, selectable
// R8: watchdog underflow or refresh error raises NMI
// R9: voltage monitor one event raises NMI
// R10: SRAM parity error raises NMI
// R11: sleep wakes on any interrupt or NMI
// R12: standby wakes on NMI or selected sources
// R13: snooze wakes on NMI or selected sources
// R14: software sets vmon1 select to enable events
// R15: each pin's edge from its own field
// R16: pins synchronised; NMI events latched until cleared
// R17: reset disables every source and request
`default_nettype none

package eir_pkg;

   // ==========================================================
   // source counts
   localparam int PERIPH_COUNT = 33;
   localparam int PIN_COUNT = 6;
   localparam int NM_COUNT = 4;

   // ==========================================================
   // nonmaskable and pin status bit positions
   localparam int NM_PIN = 0;
   localparam int NM_WATCHDOG = 1;
   localparam int NM_VMON = 2;
   localparam int NM_PARITY = 3;
   localparam int STAT_PIN_LSB = 4;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_IRQ_EN_LO = 8'h00;
   localparam logic [7:0] OFS_IRQ_EN_HI = 8'h04;
   localparam logic [7:0] OFS_XFER_EN_LO = 8'h08;
   localparam logic [7:0] OFS_XFER_EN_HI = 8'h0c;
   localparam logic [7:0] OFS_STANDBY_END_SELECT0 = 8'h10;
   localparam logic [7:0] OFS_STANDBY_END_SELECT1 = 8'h14;
   localparam logic [7:0] OFS_EXT_EDGE_CFG = 8'h18;
   localparam logic [7:0] OFS_NMI_EDGE = 8'h1c;
   localparam logic [7:0] OFS_NONMASKABLE_ENABLE = 8'h20;
   localparam logic [7:0] OFS_INT_STATUS = 8'h24;
   localparam logic [7:0] OFS_INT_MASK = 8'h28;

   // ==========================================================
   // edge select codes, two bits per pin
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;

   // ==========================================================
   // power mode codes from the power controller
   localparam logic [1:0] MODE_RUN = 2'h0;
   localparam logic [1:0] MODE_SLEEP = 2'h1;
   localparam logic [1:0] MODE_STANDBY = 2'h2;
   localparam logic [1:0] MODE_SNOOZE = 2'h3;

   // ==========================================================
   // reset values
   localparam logic [63:0] RST_ENABLE = 64'h0;
   localparam logic [31:0] RST_WORD = 32'h0;
   localparam logic RST_WAITREQUEST = 1'b1;
   localparam logic RST_FLAG = 1'b0;

endpackage : eir_pkg

`default_nettype wire

// ==== eir_req_sink.sv ====
// model of the cpu vector controller and transfer controller inputs
`default_nettype none

module eir_req_sink #(
   parameter int W = 39
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clear,
   input wire logic [W-1:0] cpu_req,
   input wire logic [W-1:0] xfer_req,
   output logic [W-1:0] cpu_seen,
   output logic [W-1:0] xfer_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [W-1:0] next_cpu_seen;
   logic [W-1:0] next_xfer_seen;

   // sticky capture, so a one-cycle pulse is never missed by a late look
   always_comb begin
      next_cpu_seen = clear ? '0 : cpu_seen | cpu_req;
      next_xfer_seen = clear ? '0 : xfer_seen | xfer_req;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cpu_seen <= '0;
         xfer_seen <= '0;
      end else begin
         cpu_seen <= next_cpu_seen;
         xfer_seen <= next_xfer_seen;
      end
   end

endmodule : eir_req_sink

`default_nettype wire

// ==== eir_router_chk.sv ====
// port-level assertion checker for the event interrupt router
`default_nettype none

module eir_router_chk #(
   parameter int PERIPH_COUNT = eir_pkg::PERIPH_COUNT,
   parameter int PIN_COUNT = eir_pkg::PIN_COUNT
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire logic [PERIPH_COUNT-1:0] periph_event,
   input wire logic [PIN_COUNT-1:0] ext_request_pin,
   input wire logic [1:0] power_mode,
   input wire logic [PERIPH_COUNT+PIN_COUNT-1:0] cpu_vector_request,
   input wire logic [PERIPH_COUNT+PIN_COUNT-1:0] transfer_request,
   input wire logic nonmaskable_request,
   input wire logic wake_request,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SRC = PERIPH_COUNT + PIN_COUNT;
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (rst);

   // ==========================================================
   // bus answer and reset state
   a_bus_one_wait: assert property (
      (read || write) && waitrequest |=> !waitrequest) else $error("bus wait too long");
   a_reset_quiet: assert property (disable iff (1'b0)
      rst |=> !irq && !nonmaskable_request && !wake_request && waitrequest
      && cpu_vector_request == '0 && transfer_request == '0) else $error("output busy in reset");

   // ==========================================================
   // maskable paths: a peripheral request needs its cause one cycle earlier
   a_cpu_from_event: assert property (
      (cpu_vector_request[PERIPH_COUNT-1:0] & ~$past(periph_event)) == '0)
      else $error("cpu request without event");
   a_xfer_from_event: assert property (
      (transfer_request[PERIPH_COUNT-1:0] & ~$past(periph_event)) == '0)
      else $error("transfer request without event");
   // pin pulse only four edges after a real pin change, so a stuck detector shows
   a_pin_edge_cause: assert property (
      (cpu_vector_request[SRC-1:PERIPH_COUNT]
      & ~($past(ext_request_pin, 4) ^ $past(ext_request_pin, 5))) == '0)
      else $error("pin request without pin edge");

   // ==========================================================
   // latched nonmaskables drop only on a read, the interrupt line on a read or a write
   a_nm_sticky: assert property (
      nonmaskable_request && !read |=> nonmaskable_request) else $error("nm request lost");
   a_irq_sticky: assert property (
      irq && !read && !write |=> irq) else $error("irq lost");

   // ==========================================================
   // wake request against power mode
   a_no_wake_run: assert property (
      power_mode == eir_pkg::MODE_RUN |=> !wake_request) else $error("wake in run mode");
   a_wake_sleep: assert property (
      $past(power_mode) == eir_pkg::MODE_SLEEP && (|cpu_vector_request) |-> wake_request)
      else $error("sleep not ended");
   a_wake_nm: assert property (
      power_mode != eir_pkg::MODE_RUN && $stable(power_mode) && nonmaskable_request && !read
      |=> wake_request) else $error("nm did not wake");

   c_pin_pulse: cover property (|cpu_vector_request[SRC-1:PERIPH_COUNT]);
   c_nm_rise: cover property ($rose(nonmaskable_request));
   c_wake_rise: cover property ($rose(wake_request));

endmodule : eir_router_chk

`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the event interrupt router
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [32:0] ev; logic [32:0] en; logic [32:0] xen;} eir_row_type;
   typedef struct {logic [3:0] src; logic sel; logic [31:0] st;} eir_nm_type;
   typedef struct {logic [1:0] mode; logic sel; logic exp;} eir_wake_type;
   eir_row_type rows [3] = '{'{33'h1_0000_0001, 33'h1_ffff_ffff, 33'h0},
      '{33'h0_aaaa_5555, 33'h0_ffff_0000, 33'h0_0f0f_0f0f},
      '{33'h1_8000_0000, 33'h1_0000_0000, 33'h1_ffff_ffff}};
   eir_nm_type nmt [5] = '{'{4'h1, 1'b1, 32'h2}, '{4'h2, 1'b1, 32'h2},
      '{4'h4, 1'b1, 32'h4}, '{4'h8, 1'b1, 32'h8}, '{4'h4, 1'b0, 32'h0}};
   eir_wake_type wk [6] = '{'{eir_pkg::MODE_SLEEP, 1'b0, 1'b1}, '{eir_pkg::MODE_STANDBY, 1'b0, 1'b0},
      '{eir_pkg::MODE_STANDBY, 1'b1, 1'b1}, '{eir_pkg::MODE_SNOOZE, 1'b1, 1'b1},
      '{eir_pkg::MODE_SNOOZE, 1'b0, 1'b0}, '{eir_pkg::MODE_RUN, 1'b1, 1'b0}};
   logic clock = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, nmi_pin = 1'b0, vsel = 1'b0;
   logic clear = 1'b0;
   logic [7:0] address = '0;
   logic [31:0] writedata = '0, readdata, q;
   logic [3:0] byteenable = '0, nmsrc = '0;
   logic [32:0] periph_event = '0;
   logic [5:0] ext_request_pin = '0;
   logic [1:0] power_mode = '0;
   logic waitrequest, nonmaskable_request, wake_request, irq;
   logic [38:0] cpu_vector_request, transfer_request, cpu_seen, xfer_seen;
   int n_mismatch = 0, cmp_count = 0;

   always #2 clock = ~clock;

   // clock enable held high: timing relations in the checker assume it
   eir_event_interrupt_router DUT (.clock(clock), .rst(rst), .ce(1'b1), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .periph_event(periph_event),
      .ext_request_pin(ext_request_pin), .nmi_pin(nmi_pin),
      .independent_watchdog_underflow(nmsrc[0]), .independent_watchdog_refresh_error(nmsrc[1]),
      .voltage_monitor_one_event(nmsrc[2]), .vmon1_irq_select(vsel), .ram_parity_event(nmsrc[3]),
      .power_mode(power_mode), .cpu_vector_request(cpu_vector_request),
      .transfer_request(transfer_request), .nonmaskable_request(nonmaskable_request),
      .wake_request(wake_request), .irq(irq));
   eir_req_sink sink (.clock(clock), .rst(rst), .clear(clear), .cpu_req(cpu_vector_request),
      .xfer_req(transfer_request), .cpu_seen(cpu_seen), .xfer_seen(xfer_seen));

   task automatic chk(input logic [38:0] g, input logic [38:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic chk1(input logic g, input logic e);
      chk({38'h0, g}, {38'h0, e});
   endtask : chk1

   // one avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      writedata <= d;
      byteenable <= 4'hf;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk({7'h0, q}, {7'h0, e});
   endtask : rd

   // one rising then one falling pin edge, counting request pulses
   task automatic pin_run(input int p, input int e);
      int c;
      c = 0;
      for (int k = 0; k < 20; k++) begin
         @(posedge clock);
         if (k == 1) ext_request_pin[p] <= 1'b1;
         if (k == 10) ext_request_pin[p] <= 1'b0;
         #1;
         if (cpu_vector_request[33 + p] === 1'b1) c++;
      end
      chk(39'(c), 39'(e));
   endtask : pin_run

   task automatic pulse(input logic [3:0] s, input logic sel);
      @(posedge clock);
      nmsrc <= s;
      vsel <= sel;
      @(posedge clock);
      nmsrc <= '0;
      repeat (2) @(posedge clock);
      #1;
   endtask : pulse

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #40000;
      n_mismatch++;
      $display("mismatch t=%0t watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      for (int a = 0; a <= 'h2c; a += 4) rd(8'(a), 32'h0);
      rd(8'h31, 32'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(eir_pkg::OFS_IRQ_EN_LO, rows[i].en[31:0]);
         wr(eir_pkg::OFS_IRQ_EN_HI, {31'h0, rows[i].en[32]});
         wr(eir_pkg::OFS_XFER_EN_LO, rows[i].xen[31:0]);
         wr(eir_pkg::OFS_XFER_EN_HI, {31'h0, rows[i].xen[32]});
         rd(eir_pkg::OFS_IRQ_EN_LO, rows[i].en[31:0]);
         @(posedge clock);
         clear <= 1'b1;
         periph_event <= rows[i].ev;
         @(posedge clock);
         clear <= 1'b0;
         periph_event <= '0;
         repeat (3) @(posedge clock);
         #1;
         chk(cpu_seen, {6'h0, rows[i].ev & rows[i].en});
         chk(xfer_seen, {6'h0, rows[i].ev & rows[i].xen});
      end
      $display("test routing rows done");
      // pin 0 falling, pin 1 rising, pin 5 both
      wr(eir_pkg::OFS_IRQ_EN_HI, 32'h7e);
      wr(eir_pkg::OFS_EXT_EDGE_CFG, 32'h804);
      pin_run(0, 1);
      pin_run(1, 1);
      pin_run(5, 2);
      rd(eir_pkg::OFS_INT_STATUS, 32'h230);
      rd(eir_pkg::OFS_INT_STATUS, 32'h0);
      $display("test pins done");
      wr(eir_pkg::OFS_INT_MASK, 32'hf);
      wr(eir_pkg::OFS_NONMASKABLE_ENABLE, 32'hf);
      wr(eir_pkg::OFS_NONMASKABLE_ENABLE, 32'h0);
      rd(eir_pkg::OFS_NONMASKABLE_ENABLE, 32'hf);
      foreach (nmt[i]) begin
         pulse(nmt[i].src, nmt[i].sel);
         chk1(nonmaskable_request, nmt[i].st != 0);
         chk1(irq, nmt[i].st != 0);
         rd(eir_pkg::OFS_INT_STATUS, nmt[i].st);
         @(posedge clock);
         #1;
         chk1(nonmaskable_request, 1'b0);
      end
      wr(eir_pkg::OFS_NMI_EDGE, 32'h1);
      @(posedge clock);
      nmi_pin <= 1'b1;
      repeat (6) @(posedge clock);
      #1;
      chk1(nonmaskable_request, 1'b1);
      rd(eir_pkg::OFS_INT_STATUS, 32'h1);
      @(posedge clock);
      nmi_pin <= 1'b0;
      repeat (6) @(posedge clock);
      #1;
      chk1(nonmaskable_request, 1'b0);
      // masked event stays off the line until the mask opens
      wr(eir_pkg::OFS_INT_MASK, 32'h0);
      pulse(4'h8, 1'b1);
      chk1(irq, 1'b0);
      wr(eir_pkg::OFS_INT_MASK, 32'h8);
      repeat (2) @(posedge clock);
      #1;
      chk1(irq, 1'b1);
      rd(eir_pkg::OFS_INT_STATUS, 32'h8);
      @(posedge clock);
      #1;
      chk1(irq, 1'b0);
      $display("test nonmaskable done");
      wr(eir_pkg::OFS_IRQ_EN_LO, 32'h1);
      foreach (wk[i]) begin
         wr(eir_pkg::OFS_STANDBY_END_SELECT0, {31'h0, wk[i].sel});
         @(posedge clock);
         power_mode <= wk[i].mode;
         periph_event <= 33'h1;
         repeat (3) @(posedge clock);
         #1;
         chk1(wake_request, wk[i].exp);
      end
      @(posedge clock);
      periph_event <= '0;
      power_mode <= eir_pkg::MODE_STANDBY;
      wr(eir_pkg::OFS_STANDBY_END_SELECT0, 32'h0);
      pulse(4'h1, 1'b1);
      chk1(wake_request, 1'b1);
      $display("test wake done");
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      rd(eir_pkg::OFS_IRQ_EN_LO, 32'h0);
      rd(eir_pkg::OFS_NONMASKABLE_ENABLE, 32'h0);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule : tb

bind eir_event_interrupt_router eir_router_chk #(.PERIPH_COUNT(PERIPH_COUNT),
   .PIN_COUNT(PIN_COUNT)) u_chk (.clock(clock), .rst(rst), .read(read), .write(write),
   .waitrequest(waitrequest), .periph_event(periph_event), .ext_request_pin(ext_request_pin),
   .power_mode(power_mode), .cpu_vector_request(cpu_vector_request),
   .transfer_request(transfer_request), .nonmaskable_request(nonmaskable_request),
   .wake_request(wake_request), .irq(irq));

`default_nettype wire
